// *** hdl/lscr_top.sv ***
// Purpose: Sink side capability registers and hot plug notification.
// Assumes: Byte wide config access on mclk; lane status on mclk.
// Notes:   Branch values are the lower of own and downstream values.
`timescale 1ns/100ps
module lscr_top (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        isBranch,
    input  wire logic [7:0]  downRevision,
    input  wire logic [7:0]  downRate,
    input  wire logic [4:0]  downLanes,
    input  wire logic        cfgRead,
    input  wire logic        cfgWrite,
    input  wire logic [19:0] cfgAddr,
    input  wire logic [7:0]  cfgWrData,
    output logic      [7:0]  cfgRdData,
    output logic             cfgRdValid,
    input  wire logic        statusChange,
    output logic             hotPlugDetect,
    input  wire logic        streamStable,
    output logic             displayBlank,
    input  wire logic [3:0]  laneBitLock,
    input  wire logic [3:0]  laneSymLock,
    input  wire logic [3:0]  laneSkewOk,
    input  wire logic [4:0]  trainLaneCount,
    output logic             trainPass
);
    // ------------------------------------------------------------------
    // Capability values
    // ------------------------------------------------------------------
    localparam logic [7:0] OWN_REV = {lscr_pkg::REV_MAJOR_OWN,
                                      lscr_pkg::REV_MINOR_OWN};

    logic [7:0] revValue;
    logic [7:0] rateValue;
    logic [4:0] lanesValue;
    logic [7:0] downRateLegal;
    logic [4:0] downLanesLegal;

    // Reserved downstream codes fall back to the lowest legal code.
    assign downRateLegal  = (downRate == lscr_pkg::RATE_HIGH) ?
                            lscr_pkg::RATE_HIGH : lscr_pkg::RATE_LOW;
    assign downLanesLegal = (downLanes == lscr_pkg::LANES_FOUR ||
                             downLanes == lscr_pkg::LANES_TWO) ?
                            downLanes : lscr_pkg::LANES_ONE;

    // A branch reports the lowest common value on each field.
    always_comb begin
        revValue   = OWN_REV;
        rateValue  = lscr_pkg::RATE_OWN;
        lanesValue = lscr_pkg::LANES_OWN;
        if (isBranch) begin
            if (downRevision < OWN_REV) begin
                revValue = downRevision;
            end
            if (downRateLegal < lscr_pkg::RATE_OWN) begin
                rateValue = downRateLegal;
            end
            if (downLanesLegal < lscr_pkg::LANES_OWN) begin
                lanesValue = downLanesLegal;
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte addressed configuration reads
    // ------------------------------------------------------------------
    // One byte per access; writes are accepted and dropped.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfgRdData  <= 8'h00;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgRead && !cfgWrite;
            if (cfgRead && !cfgWrite) begin
                unique case (cfgAddr)
                    lscr_pkg::REVISION_ADDR: cfgRdData <= revValue;
                    lscr_pkg::RATE_ADDR:     cfgRdData <= rateValue;
                    // Bits 7:5 of the lane count byte read as zero.
                    lscr_pkg::LANES_ADDR: begin
                        cfgRdData <= {3'h0, lanesValue};
                    end
                    default: begin
                        cfgRdData <= lscr_pkg::UNMAPPED_DATA;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Hot plug notification pulse
    // ------------------------------------------------------------------
    localparam int CW = $clog2(lscr_pkg::HPD_LOW_CYC + 1);
    localparam logic [CW-1:0] LOW_LAST = CW'(lscr_pkg::HPD_LOW_CYC - 1);
    logic [CW-1:0] lowCount_q;
    logic          pulsing_q;
    logic          pending_q;

    // A change during a pulse is held and sent after the line goes high.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pulsing_q     <= 1'b0;
            pending_q     <= 1'b0;
            lowCount_q    <= '0;
            hotPlugDetect <= 1'b0;
        end else if (pulsing_q) begin
            if (statusChange) begin
                pending_q <= 1'b1;
            end
            if (lowCount_q == LOW_LAST) begin
                pulsing_q     <= 1'b0;
                hotPlugDetect <= 1'b1;
            end else begin
                lowCount_q <= lowCount_q + CW'(1);
            end
        end else if (statusChange || pending_q) begin
            pulsing_q     <= 1'b1;
            pending_q     <= 1'b0;
            lowCount_q    <= '0;
            hotPlugDetect <= 1'b0;
        end else begin
            hotPlugDetect <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Display blanking and training status
    // ------------------------------------------------------------------
    lscr_lane_if laneBus ();
    assign laneBus.bitLock   = laneBitLock;
    assign laneBus.symLock   = laneSymLock;
    assign laneBus.skewOk    = laneSkewOk;
    assign laneBus.laneCount = trainLaneCount;

    lscr_train_check u_train (
        .lanes (laneBus.chk)
    );

    // Blank while unstable; register the training verdict.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            displayBlank <= 1'b1;
            trainPass    <= 1'b0;
        end else begin
            displayBlank <= !streamStable;
            trainPass    <= laneBus.trainPass;
        end
    end
endmodule

// *** hdl/lscr_pkg.sv ***
// Purpose: Constants for the sink link setup and capability block.
// Assumes: One 125 MHz clock, byte wide configuration space.
// Notes:   Times are held in microseconds and turned into cycle counts.
package lscr_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [19:0] REVISION_ADDR  = 20'h00000;
    localparam logic [19:0] RATE_ADDR      = 20'h00001;
    localparam logic [19:0] LANES_ADDR     = 20'h00002;
    // ------------------------------------------------------------------
    // Field layouts and encodings
    // ------------------------------------------------------------------
    localparam int          REV_MINOR_LSB  = 0;
    localparam int          REV_MAJOR_LSB  = 4;
    localparam logic [3:0]  REV_MAJOR_OWN  = 4'h1;
    localparam logic [3:0]  REV_MINOR_OWN  = 4'h0;
    localparam logic [7:0]  RATE_LOW       = 8'h06;
    localparam logic [7:0]  RATE_HIGH      = 8'h0A;
    localparam logic [4:0]  LANES_ONE      = 5'h01;
    localparam logic [4:0]  LANES_TWO      = 5'h02;
    localparam logic [4:0]  LANES_FOUR     = 5'h04;
    localparam logic [7:0]  RATE_OWN       = 8'h0A;
    localparam logic [4:0]  LANES_OWN      = 5'h04;
    localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ        = 125;
    localparam int          HPD_LOW_MIN_US = 500;
    localparam int          HPD_LOW_MAX_US = 1000;
    // Pulse sits midway in the allowed window to tolerate clock error.
    localparam int          HPD_LOW_US     =
        (HPD_LOW_MIN_US + HPD_LOW_MAX_US) / 2;
    localparam int          HPD_LOW_CYC    = HPD_LOW_US * CLK_MHZ;
    localparam int          SKEW_MAX_SYM   = 2;
    localparam int          NUM_LANES      = 4;
endpackage

// *** hdl/lscr_lane_if.sv ***
// Purpose: Carries per lane lock and skew status into the checker.
// Assumes: Lane status comes from logic on mclk.
// Notes:   Skew is in link symbol clock periods.
`timescale 1ns/100ps
interface lscr_lane_if;
    logic [3:0] bitLock;
    logic [3:0] symLock;
    logic [3:0] skewOk;
    logic [4:0] laneCount;
    logic       trainPass;
    modport top  (output bitLock, symLock, skewOk, laneCount, input trainPass);
    modport chk  (input bitLock, symLock, skewOk, laneCount, output trainPass);
endinterface

// *** hdl/lscr_train_check.sv ***
// Purpose: Decides whether link training has passed on configured lanes.
// Assumes: Inputs are stable on mclk; skewOk per lane is versus lane-1.
// Notes:   Unsupported lane counts never pass.
`timescale 1ns/100ps
module lscr_train_check (
    lscr_lane_if.chk lanes
);
    logic [3:0] laneUsed;
    logic [3:0] laneGood;

    // Lanes in use follow the configured count.
    always_comb begin
        unique case (lanes.laneCount)
            lscr_pkg::LANES_ONE:  laneUsed = 4'h1;
            lscr_pkg::LANES_TWO:  laneUsed = 4'h3;
            lscr_pkg::LANES_FOUR: laneUsed = 4'hF;
            default:              laneUsed = 4'h0;
        endcase
    end

    // Each used lane needs both locks; used lanes above 0 also need alignment to lane-1.
    genvar i;
    generate
        for (i = 0; i < lscr_pkg::NUM_LANES; i++) begin : g_lane
            assign laneGood[i] = !laneUsed[i] ||
                (lanes.bitLock[i] && lanes.symLock[i] &&
                 (i == 0 || lanes.skewOk[i]));
        end
    endgenerate

    // Pass only with a legal lane count and every used lane good.
    assign lanes.trainPass = (laneUsed != 4'h0) && (&laneGood);
endmodule

// *** tb/lscr_sva.sv ***
// Purpose: Port assertions for the capability block.
// Assumes: One mclk domain, rstn active low.
// Notes:   Bound to every lscr_top.
`timescale 1ns/100ps
module lscr_sva (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        isBranch,
    input wire logic        cfgRead,
    input wire logic        cfgWrite,
    input wire logic [19:0] cfgAddr,
    input wire logic [7:0]  cfgRdData,
    input wire logic        cfgRdValid,
    input wire logic        statusChange,
    input wire logic        hotPlugDetect,
    input wire logic        streamStable,
    input wire logic        displayBlank,
    input wire logic [3:0]  laneBitLock,
    input wire logic [3:0]  laneSymLock,
    input wire logic [4:0]  trainLaneCount,
    input wire logic        trainPass
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [16:0] lowCnt_q;
    logic        seenHigh_q;
    logic        rd;
    assign rd = cfgRead && !cfgWrite;
    // Counts low cycles of hot plug; the reset low is not a pulse.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_q   <= 17'h00000;
            seenHigh_q <= 1'b0;
        end else begin
            lowCnt_q   <= hotPlugDetect ? 17'h00000 : lowCnt_q + 17'h00001;
            seenHigh_q <= seenHigh_q | hotPlugDetect;
        end
    end
    a_read_answer: assert property (rd |=> cfgRdValid)
        else $error("read not answered");
    a_write_silent: assert property (!rd |=> !cfgRdValid)
        else $error("answer without read");
    a_rev_fields: assert property (rd && cfgAddr == 20'h00000 &&
        !isBranch |=> cfgRdData == 8'h10) else $error("bad revision");
    a_rate_legal: assert property (rd && cfgAddr == 20'h00001 |=>
        cfgRdData inside {8'h06, 8'h0A}) else $error("bad rate");
    a_lanes_legal: assert property (rd && cfgAddr == 20'h00002 |=>
        cfgRdData inside {8'h01, 8'h02, 8'h04}) else $error("bad lanes");
    a_hpd_width: assert property ($rose(hotPlugDetect) && seenHigh_q |->
        lowCnt_q == 17'(lscr_pkg::HPD_LOW_CYC)) else $error("bad pulse");
    a_hpd_start: assert property (statusChange && hotPlugDetect |=>
        !hotPlugDetect) else $error("no pulse");
    a_blank_follow: assert property (1'b1 |=>
        displayBlank == !$past(streamStable)) else $error("bad blank");
    a_train_one: assert property (trainLaneCount == 5'h01 &&
        laneBitLock[0] && laneSymLock[0] |=> trainPass) else $error("no pass");
endmodule
bind lscr_top lscr_sva u_sva (.mclk, .rstn, .isBranch, .cfgRead, .cfgWrite,
    .cfgAddr, .cfgRdData, .cfgRdValid, .statusChange, .hotPlugDetect,
    .streamStable, .displayBlank, .laneBitLock, .laneSymLock,
    .trainLaneCount, .trainPass);

// *** tb/lscr_source_model.sv ***
// Purpose: Source model that reads sink capability bytes.
// Assumes: Sink answers on the taking edge itself; data is read 1 ns later.
// Notes:   The bench calls access in sequence.
`timescale 1ns/100ps
module lscr_source_model (
    input  wire logic        mclk,
    input  wire logic        cfgRdValid,
    input  wire logic [7:0]  cfgRdData,
    output logic             cfgRead,
    output logic             cfgWrite,
    output logic [19:0]      cfgAddr,
    output logic [7:0]       cfgWrData
);
    // Idle bus until the first access, so no unknown reaches the sink.
    initial begin
        cfgRead   = 1'b0;
        cfgWrite  = 1'b0;
        cfgAddr   = 20'h00000;
        cfgWrData = 8'h00;
    end
    // One byte access, held across the taking edge.
    task automatic access(input logic rd, wr, input logic [19:0] a,
                          input logic [7:0] wd, output logic [7:0] q,
                          output logic v);
        @(posedge mclk);
        #1;
        cfgRead   = rd;
        cfgWrite  = wr;
        cfgAddr   = a;
        cfgWrData = wd;
        @(posedge mclk);
        #1;
        q         = cfgRdData;
        v         = cfgRdValid;
        cfgRead   = 1'b0;
        cfgWrite  = 1'b0;
        cfgWrData = ~wd;
    endtask
endmodule

// *** tb/link_setup_capability_regs_test.sv ***
// Purpose: Self-checking bench for lscr_top.
// Assumes: 125 MHz mclk, inputs change 1 ns after the edge.
// Notes:   Seed 52; one full hot plug pulse is run.
`timescale 1ns/100ps
module link_setup_capability_regs_test;
    logic        mclk, rstn, isBranch, statusChange, streamStable;
    logic        cfgRead, cfgWrite, cfgRdValid, hotPlugDetect;
    logic        displayBlank, trainPass, v;
    logic [7:0]  downRevision, downRate, cfgWrData, cfgRdData, q;
    logic [4:0]  downLanes, trainLaneCount;
    logic [3:0]  laneBitLock, laneSymLock, laneSkewOk;
    logic [19:0] cfgAddr;
    int          fail_count, n_checks, k;
    lscr_top u_lscr_top (.mclk, .rstn, .isBranch, .downRevision, .downRate,
        .downLanes, .cfgRead, .cfgWrite, .cfgAddr, .cfgWrData, .cfgRdData,
        .cfgRdValid, .statusChange, .hotPlugDetect, .streamStable,
        .displayBlank, .laneBitLock, .laneSymLock, .laneSkewOk,
        .trainLaneCount, .trainPass);
    lscr_source_model u_lscr_source_model (.mclk, .cfgRdValid, .cfgRdData,
        .cfgRead, .cfgWrite, .cfgAddr, .cfgWrData);
    // Compares and counts.
    task automatic check(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // Prints counts and verdict.
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Expected capability byte; reserved downstream codes fall back.
    function automatic logic [7:0] capExp(input logic [1:0] a);
        if (a == 2'h3)
            return 8'h00;
        if (!isBranch)
            return a == 2'h0 ? 8'h10 : a == 2'h1 ? 8'h0A : 8'h04;
        if (a == 2'h0)
            return downRevision < 8'h10 ? downRevision : 8'h10;
        if (a == 2'h1)
            return downRate == 8'h0A ? 8'h0A : 8'h06;
        return downLanes inside {5'h01, 5'h02, 5'h04} ? 8'(downLanes) : 8'h01;
    endfunction
    // Expected training verdict over the used lanes.
    function automatic logic trainExp(input logic [4:0] n);
        logic [3:0] m;
        m = n == 5'h01 ? 4'h1 : n == 5'h02 ? 4'h3 : n == 5'h04 ? 4'hF : 4'h0;
        return m != 4'h0 && (m & laneBitLock & laneSymLock) == m
               && ((laneSkewOk | 4'h1) & m) == m;
    endfunction
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {rstn, isBranch, statusChange, streamStable} = 4'h0;
        {downRevision, downRate, downLanes} = 21'h00000;
        {laneBitLock, laneSymLock, laneSkewOk, trainLaneCount} = 17'h00000;
        fail_count = 0;
        n_checks = 0;
        k = $urandom(52);
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        @(posedge mclk);
        #1;
        check(hotPlugDetect, 1);
        check(cfgRdValid, 0);
        // Own values, unmapped byte, writes that must change nothing.
        for (k = 0; k < 4; k++) begin
            u_lscr_source_model.access(1, 1, 20'(k), 8'hFF, q, v);
            check(v, 0);
            u_lscr_source_model.access(0, 1, 20'(k), 8'h5A, q, v);
            u_lscr_source_model.access(1, 0, 20'(k), 8'h00, q, v);
            check(q, capExp(k[1:0]));
        end
        // Random branch values, lane status and stream stability.
        repeat (40) begin
            @(posedge mclk);
            #1;
            isBranch = 1'($urandom);
            downRevision = 8'($urandom);
            downRate = $urandom_range(0, 1) ? 8'h0A : 8'($urandom % 8);
            downLanes = 5'($urandom);
            laneBitLock = $urandom_range(0, 1) ? 4'hF : 4'($urandom);
            laneSymLock = $urandom_range(0, 1) ? 4'hF : 4'($urandom);
            laneSkewOk = $urandom_range(0, 1) ? 4'hF : 4'($urandom);
            trainLaneCount = 5'($urandom_range(0, 5));
            streamStable = 1'($urandom);
            @(posedge mclk);
            #1;
            check(trainPass, trainExp(trainLaneCount));
            check(displayBlank, !streamStable);
            for (k = 0; k < 3; k++) begin
                u_lscr_source_model.access(1, 0, 20'(k), 8'h00, q, v);
                check(q, capExp(k[1:0]));
                check(v, 1);
            end
        end
        // One status change; measure the low pulse, then read at once.
        statusChange = 1'b1;
        @(posedge mclk);
        #1;
        statusChange = 1'b0;
        check(hotPlugDetect, 0);
        for (k = 1; !hotPlugDetect && k < 100000; k++) begin
            @(posedge mclk);
            #1;
        end
        check(k - 1, lscr_pkg::HPD_LOW_CYC);
        check(k - 1 > 250 * lscr_pkg::CLK_MHZ, 1);
        u_lscr_source_model.access(1, 0, 20'h00000, 8'h00, q, v);
        check(q, capExp(2'h0));
        results();
    end
endmodule
